// ===== rtl/tflu_unit.sv
// Overview of operation
// - memory-flag ops combine test flag with flag
// - load copies memory flag, inverted if set
// - or with memory flag, optionally inverted
// - and with memory flag, optionally inverted
// - xor uses reversed invert polarity
// - store writes test flag to memory flag
// - clear/set force memory flag, flags unchanged
// - condition load writes condition truth value
// - condition or updates test flag
// - condition and updates test flag
// - condition xor or xnor by invert bit
// - test flags drive branch conditions
// - flags hold until affecting instruction
// - condition field picks one of 32 conditions
`timescale 1ns/1ps
`include "tflu_consts.svh"

module tflu_unit (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 instr_valid,
    input  wire logic [16:0]          instr_word,
    input  wire logic                 mem_flag_bit,
    input  wire logic [31:0]          cond_status,
    output tflu_pkg::tflu_tf_t        test_flags,
    output tflu_pkg::tflu_mwr_t       mem_write,
    output logic                      cond_true
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [4:0] cls;
    logic       flg;
    logic       inv;
    logic [2:0] mop;
    logic [1:0] cop;
    logic [4:0] condition_code;
    logic [4:0] key;
    logic       is_mem;
    logic       is_cond;
    logic       is_clr;
    logic       is_set;

    always_comb begin
        cls            = instr_word[`TFLU_CLS_HI:`TFLU_CLS_LO];
        flg            = instr_word[`TFLU_FLG_BIT];
        inv            = instr_word[`TFLU_NOT_BIT];
        mop            = instr_word[`TFLU_C8A_HI:`TFLU_C8A_LO];
        cop            = instr_word[`TFLU_C8B_HI:`TFLU_C8B_LO];
        condition_code = instr_word[`TFLU_CC_HI:`TFLU_CC_LO];
        key            = {flg, inv, mop};
        is_mem         = instr_valid && (cls == `TFLU_CLS_MEMFLAG);
        is_cond        = instr_valid && (cls == `TFLU_CLS_COND);
        // clear and set reuse op codes 3 and 5 with fixed flag and invert bits
        is_clr         = is_mem && (key == `TFLU_CLR_KEY);
        is_set         = is_mem && (key == `TFLU_SET_KEY);
    end

    // ----------------------------------------------------------------
    // flag state
    // ----------------------------------------------------------------
    logic      tf1_reg;
    logic      tf2_reg;
    logic      tf1_next;
    logic      tf2_next;
    tflu_pkg::tflu_mwr_t mwr_reg;
    tflu_pkg::tflu_mwr_t mwr_next;
    logic      ct_reg;
    logic      ct_next;
    logic      old_tf;
    logic      res;
    logic      upd;
    logic      cond_val;
    logic      mflag;

    always_comb begin
        old_tf   = flg ? tf2_reg : tf1_reg;
        // other codes read their cond_status bit; test flags feed back directly
        cond_val = cond_status[condition_code];
        if (condition_code == `TFLU_CC_TF1) cond_val = tf1_reg;
        if (condition_code == `TFLU_CC_TF2) cond_val = tf2_reg;
        mflag    = mem_flag_bit;
        res      = old_tf;
        upd      = 1'b0;
        mwr_next = '0;
        mwr_next.flag_addr = instr_word[`TFLU_FADR_HI:`TFLU_FADR_LO];
        tf1_next = tf1_reg;
        tf2_next = tf2_reg;
        ct_next  = cond_val ^ inv;
        if (is_clr || is_set) begin
            mwr_next.wr    = 1'b1;
            mwr_next.value = is_set;
        end else if (is_mem) begin
            upd = 1'b1;
            unique case (mop)
                tflu_pkg::TFLU_M_LOAD:  res = mflag ^ inv;
                tflu_pkg::TFLU_M_OR:    res = old_tf | (mflag ^ inv);
                tflu_pkg::TFLU_M_AND:   res = old_tf & (mflag ^ inv);
                tflu_pkg::TFLU_M_XOR:   res = old_tf ^ mflag ^ ~inv;
                tflu_pkg::TFLU_M_STORE: begin
                    upd            = 1'b0;
                    mwr_next.wr    = 1'b1;
                    mwr_next.value = old_tf;
                end
                // other codes outside the clear/set keys are reserved: a stray
                // word then changes nothing rather than corrupting a flag
                default: upd = 1'b0;
            endcase
        end else if (is_cond) begin
            upd = 1'b1;
            unique case (cop)
                tflu_pkg::TFLU_C_LOAD: res = cond_val ^ inv;
                tflu_pkg::TFLU_C_OR:   res = old_tf | (cond_val ^ inv);
                tflu_pkg::TFLU_C_AND:  res = old_tf & (cond_val ^ inv);
                tflu_pkg::TFLU_C_XOR:  res = old_tf ^ cond_val ^ ~inv;
            endcase
        end
        if (upd && !flg) tf1_next = res;
        if (upd && flg)  tf2_next = res;
    end

    // everything the core sees is registered, so no output has logic after a flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tf1_reg <= `TFLU_TF_RESET;
            tf2_reg <= `TFLU_TF_RESET;
            mwr_reg <= '0;
            ct_reg  <= 1'b0;
        end else begin
            tf1_reg <= tf1_next;
            tf2_reg <= tf2_next;
            mwr_reg <= mwr_next;
            ct_reg  <= ct_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign test_flags.test_flag_one = tf1_reg;
    assign test_flags.test_flag_two = tf2_reg;
    assign mem_write                = mwr_reg;
    assign cond_true                = ct_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    mem_load_a: assert property (is_mem && key[2:0] == 3'h0 && !flg |=>
        tf1_reg == ($past(mem_flag_bit) ^ $past(inv)))
        else $error("memory flag load wrong");
    mem_or_a: assert property (is_mem && mop == 3'h2 && !flg |=>
        tf1_reg == ($past(tf1_reg) | ($past(mem_flag_bit) ^ $past(inv))))
        else $error("memory flag or wrong");
    mem_and_a: assert property (is_mem && mop == 3'h4 && flg |=>
        tf2_reg == ($past(tf2_reg) & ($past(mem_flag_bit) ^ $past(inv))))
        else $error("memory flag and wrong");
    mem_xor_a: assert property (is_mem && mop == 3'h6 && !flg |=>
        tf1_reg == ($past(tf1_reg) ^ $past(mem_flag_bit) ^ !$past(inv)))
        else $error("memory flag xor wrong");
    store_flag_a: assert property (is_mem && mop == 3'h1 && !is_clr && !is_set |=>
        mem_write.wr && mem_write.value == $past(old_tf))
        else $error("store flag wrong");
    set_clear_a: assert property (is_set || is_clr |=>
        mem_write.wr && mem_write.value == $past(is_set) && $stable(tf1_reg) && $stable(tf2_reg))
        else $error("set or clear flag wrong");
    cond_xor_a: assert property (is_cond && cop == 2'h3 && flg |=>
        tf2_reg == ($past(tf2_reg) ^ $past(cond_val) ^ !$past(inv)))
        else $error("condition xor wrong");
    flags_hold_a: assert property (!is_mem && !is_cond |=>
        $stable(tf1_reg) && $stable(tf2_reg))
        else $error("test flags changed without instruction");
    cond_load_a: assert property (is_cond && cop == 2'h0 && !flg |=>
        tf1_reg == ($past(cond_val) ^ $past(inv)))
        else $error("condition load wrong");

    // ----------------------------------------------------------------
    // assertions: both flags, selection, writes and condition output
    // ----------------------------------------------------------------
    mem_load_two_a: assert property (is_mem && mop == 3'h0 && flg |=>
        tf2_reg == ($past(mem_flag_bit) ^ $past(inv)))
        else $error("memory flag load on second flag wrong");
    mem_and_one_a: assert property (is_mem && mop == 3'h4 && !flg |=>
        tf1_reg == ($past(tf1_reg) & ($past(mem_flag_bit) ^ $past(inv))))
        else $error("memory flag and on first flag wrong");
    mem_or_two_a: assert property (is_mem && mop == 3'h2 && flg |=>
        tf2_reg == ($past(tf2_reg) | ($past(mem_flag_bit) ^ $past(inv))))
        else $error("memory flag or on second flag wrong");
    cond_or_a: assert property (is_cond && cop == 2'h1 && !flg |=>
        tf1_reg == ($past(tf1_reg) | ($past(cond_val) ^ $past(inv))))
        else $error("condition or wrong");
    cond_and_a: assert property (is_cond && cop == 2'h2 && flg |=>
        tf2_reg == ($past(tf2_reg) & ($past(cond_val) ^ $past(inv))))
        else $error("condition and wrong");
    cond_load_two_a: assert property (is_cond && cop == 2'h0 && flg |=>
        tf2_reg == ($past(cond_val) ^ $past(inv)))
        else $error("condition load on second flag wrong");
    // the unselected flag must survive any update of its partner
    flag_select_a: assert property (is_cond || (is_mem && !mop[0]) |=>
        ($past(flg) ? $stable(tf1_reg) : $stable(tf2_reg)))
        else $error("unselected test flag changed");
    mem_hold_a: assert property (is_mem && mop[0] |=>
        $stable(tf1_reg) && $stable(tf2_reg))
        else $error("test flags changed by store or flag write");
    write_only_a: assert property (!is_mem |=> !mem_write.wr)
        else $error("memory flag written outside memory-flag class");
    write_addr_a: assert property (is_mem && mop == 3'h1 |=>
        mem_write.flag_addr == $past(instr_word[`TFLU_FADR_HI:`TFLU_FADR_LO]))
        else $error("memory flag address wrong");
    // a branch tests the flag as left by the words before it
    tf_feed_a: assert property (condition_code == `TFLU_CC_TF1 |=>
        cond_true == ($past(tf1_reg) ^ $past(inv)))
        else $error("test flag not seen as branch condition");
    cond_true_a: assert property (!instr_word[`TFLU_CC_HI] |=>
        cond_true == ($past(cond_status[condition_code]) ^ $past(inv)))
        else $error("condition truth value wrong");

    // main scenarios: flag xor, store, set then clear, chained condition ops
    cov_mem_xor_c: cover property (is_mem && mop == 3'h6);
    cov_store_c: cover property (is_mem && mop == 3'h1);
    cov_set_c: cover property (is_set ##1 is_clr);
    cov_cond_and_c: cover property (is_cond && cop == 2'h2 ##1 is_cond && cop == 2'h3);
    cov_tf_feed_c: cover property (is_cond && condition_code == `TFLU_CC_TF2);

endmodule

// ===== common/tflu_consts.svh
`ifndef TFLU_CONSTS_SVH
`define TFLU_CONSTS_SVH

// instruction word layout (17 bits)
`define TFLU_IW_MSB        16
`define TFLU_CLS_HI        16
`define TFLU_CLS_LO        12
`define TFLU_CLS_MEMFLAG   5'h13
`define TFLU_CLS_COND      5'h12
`define TFLU_FLG_BIT       11
`define TFLU_NOT_BIT       10
`define TFLU_C8A_HI        9
`define TFLU_C8A_LO        7
`define TFLU_FADR_HI       6
`define TFLU_FADR_LO       0
`define TFLU_CC_HI         9
`define TFLU_CC_LO         5
`define TFLU_C8B_HI        1
`define TFLU_C8B_LO        0
// special memory-flag encodings: flg/not/c8a
`define TFLU_CLR_KEY       5'h03
`define TFLU_SET_KEY       5'h15
// memory word: 16 data bits plus flag bit
`define TFLU_MEM_FLAG_BIT  16
`define TFLU_NUM_COND      32
`define TFLU_CC_TF1        5'h10
`define TFLU_CC_TF2        5'h11
`define TFLU_TF_RESET      1'b0

`endif

// ===== common/tflu_pkg.sv
package tflu_pkg;

    typedef enum logic [2:0] {
        TFLU_M_LOAD  = 3'h0,
        TFLU_M_OR    = 3'h2,
        TFLU_M_AND   = 3'h4,
        TFLU_M_XOR   = 3'h6,
        TFLU_M_STORE = 3'h1
    } tflu_mop_t;

    typedef enum logic [1:0] {
        TFLU_C_LOAD = 2'h0,
        TFLU_C_OR   = 2'h1,
        TFLU_C_AND  = 2'h2,
        TFLU_C_XOR  = 2'h3
    } tflu_cop_t;

    // memory-flag write request toward data memory
    typedef struct packed {
        logic       wr;
        logic [6:0] flag_addr;
        logic       value;
    } tflu_mwr_t;

    // test flags presented to the branch unit
    typedef struct packed {
        logic test_flag_two;
        logic test_flag_one;
    } tflu_tf_t;

endpackage

// ===== dv/tflu_unit_tb.sv
`timescale 1ns/1ps
module tflu_unit_tb;
    // --------
    // signals
    // --------
    logic                clk = 1'b0;
    logic                rst_b = 1'b0;
    logic                instr_valid = 1'b0;
    logic [16:0]         instr_word = 17'h00000;
    logic                mem_flag_bit = 1'b0;
    logic [31:0]         cond_status = 32'h00000000;
    tflu_pkg::tflu_tf_t  test_flags;
    tflu_pkg::tflu_mwr_t mem_write;
    logic                cond_true;
    logic [31:0]         seed = 32'hf5806657;
    int                  n_fail = 0;
    int                  total_checks = 0;
    logic [1:0]          tf_m = 2'h0;
    logic [8:0]          exp_wr;
    logic                exp_ct;
    logic                ct_valid;
    int                  kind_m;

    always #50 clk = ~clk;

    tflu_unit u_tflu_unit (
        .clk          (clk),
        .rst_b        (rst_b),
        .instr_valid  (instr_valid),
        .instr_word   (instr_word),
        .mem_flag_bit (mem_flag_bit),
        .cond_status  (cond_status),
        .test_flags   (test_flags),
        .mem_write    (mem_write),
        .cond_true    (cond_true)
    );

    // --------
    // helpers
    // --------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_flags();
        cmp("test_flags", {10'h000, tf_m}, {10'h000, test_flags});
    endtask

    task automatic cmp_write();
        cmp("write strobe", {11'h000, exp_wr[8]}, {11'h000, mem_write.wr});
        if (exp_wr[8])
            cmp("mem_write", {3'h0, exp_wr}, {3'h0, mem_write});
    endtask

    task automatic cmp_cond();
        if (ct_valid)
            cmp("cond_true", {11'h000, exp_ct}, {11'h000, cond_true});
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // mostly the two flag classes, a quarter random class codes whose foreign ones must be ignored
    task automatic drive();
        seed = xs(seed);
        instr_word = seed[16:0];
        instr_word[16:12] = (seed[31:30] == 2'h3) ? seed[21:17] : {4'h9, seed[29]};
        instr_valid = (seed[28:26] != 3'h0);
        mem_flag_bit = seed[25];
        seed = xs(seed);
        cond_status = seed;
    endtask

    // --------
    // model
    // --------
    task automatic model_step();
        logic f, n, c, t, r;
        logic [2:0] op;
        f = instr_word[11];
        n = instr_word[10];
        op = instr_word[9:7];
        t = tf_m[f];
        r = t;
        exp_wr = 9'h000;
        ct_valid = 1'b0;
        kind_m = 0;
        if (instr_valid && instr_word[16:12] == 5'h13) begin
            c = mem_flag_bit;
            kind_m = op[0] ? 0 : 1;
            if (instr_word[11:7] == 5'h03 || instr_word[11:7] == 5'h15)
                exp_wr = {1'b1, instr_word[6:0], f};
            else if (op == 3'h1)
                exp_wr = {1'b1, instr_word[6:0], t};
            else if (op == 3'h0)
                r = c ^ n;
            else if (op == 3'h2)
                r = t | (c ^ n);
            else if (op == 3'h4)
                r = t & (c ^ n);
            else if (op == 3'h6)
                r = t ^ c ^ ~n;
        end else if (instr_valid && instr_word[16:12] == 5'h12) begin
            c = (instr_word[9:5] == 5'h10) ? tf_m[0] :
                (instr_word[9:5] == 5'h11) ? tf_m[1] : cond_status[instr_word[9:5]];
            exp_ct = c ^ n;
            ct_valid = 1'b1;
            kind_m = 2;
            case (instr_word[1:0])
                2'h0: r = c ^ n;
                2'h1: r = t | (c ^ n);
                2'h2: r = t & (c ^ n);
                default: r = t ^ c ^ ~n;
            endcase
        end
        tf_m[f] = r;
    endtask

    task automatic reset_check();
        cmp("reset outputs", 12'h000, {test_flags, mem_write, cond_true});
    endtask

    // --------
    // sequence
    // --------
    initial begin
        repeat (5) @(posedge clk);
        #1;
        reset_check();
        rst_b = 1'b1;
        for (int i = 0; i < 3000; i++) begin
            if (i == 1500) begin
                rst_b = 1'b0;
                tf_m = 2'h0;
                #1;
                reset_check();
                @(posedge clk);
                #1;
                rst_b = 1'b1;
            end
            drive();
            model_step();
            @(posedge clk);
            #1;
            case (kind_m)
                1: cmp_flags();
                2: cmp_flags();
                default: cmp_flags();
            endcase
            cmp_write();
            cmp_cond();
        end
        conclude();
    end

    // hang guard, well past the 3000 planned cycles
    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule
